// >>> rtl/ubd_pkg.sv
// Shared constants and carrier types of the baud rate divider.
// Assumes a single main clock; all slower rates are one-cycle enables.
package ubd_pkg;
	// ------------------------------------------------------------
	// Channel count and register indices (byte address = 4 x index)
	// ------------------------------------------------------------
	localparam int          NCH        = 3;
	localparam logic [31:0] IDX_CTL [NCH] = '{32'hFFFFFA00, 32'hFFFFFA10, 32'hFFFFFA30};
	localparam logic [31:0] IDX_CKS [NCH] = '{32'hFFFFFA01, 32'hFFFFFA11, 32'hFFFFFA31};
	localparam logic [31:0] IDX_DIV [NCH] = '{32'hFFFFFA02, 32'hFFFFFA12, 32'hFFFFFA32};

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          CTL_PWR_BIT   = 0;
	localparam int          CTL_TXE_BIT   = 1;
	localparam int          CTL_RXE_BIT   = 2;
	localparam int          CTL_RXACT_BIT = 4;
	localparam int          CKS_W         = 4;
	localparam int          DIV_W         = 8;
	localparam logic [3:0]  CKS_MAX_INT   = 4'hA;
	localparam logic [3:0]  CKS_EXT       = 4'hB;
	localparam logic [3:0]  CKS_RST       = 4'h0;
	localparam logic [7:0]  DIV_MIN       = 8'h04;
	localparam logic [7:0]  DIV_RST       = 8'hFF;
	localparam logic        CTL_BIT_RST   = 1'b0;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam int          PRE_W         = 10;
	localparam logic [3:0]  FRAME_BITS    = 4'hB;

	// ------------------------------------------------------------
	// Bus responses and register kinds
	// ------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [1:0]  KIND_CTL      = 2'h0;
	localparam logic [1:0]  KIND_CKS      = 2'h1;
	localparam logic [1:0]  KIND_DIV      = 2'h2;

	typedef struct packed {
		logic             power;
		logic             txe;
		logic             rxe;
		logic [CKS_W-1:0] cks;
		logic [DIV_W-1:0] div;
	} ubd_cfg_s;

	typedef struct packed {
		logic       hit;
		logic [1:0] ch;
		logic [1:0] kind;
	} ubd_dec_s;
endpackage

// >>> rtl/ubd_div_counter.sv
// One 8-bit divide-by-k counter clocked by base clock enables.
// Assumes run_i and div_i are steady while a frame is being timed.
`timescale 1ns/1ps
module ubd_div_counter
	import ubd_pkg::*;
#(
	parameter int W             = DIV_W,
	parameter bit FIRST_AT_HALF = 1'b0
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	// Control
	input  wire logic         run_i,
	input  wire logic         restart_i,
	input  wire logic         base_en_i,
	input  wire logic [W-1:0] div_i,
	// Ticks
	output logic              sclk_o,
	output logic              bit_o
);
	logic [W-1:0] cnt_q;
	logic         phase_q;
	logic         sclk_q;
	logic         bit_q;
	logic         wrap;

	// ------------------------------------------------------------
	// Count k base clocks, then wrap
	// ------------------------------------------------------------
	assign wrap = run_i & ~restart_i & base_en_i & (cnt_q == (div_i - W'(1)));

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q   <= '0;
			phase_q <= 1'b0;
		end else if (!run_i || restart_i) begin
			cnt_q   <= '0;
			phase_q <= FIRST_AT_HALF;
		end else if (base_en_i) begin
			if (wrap) begin
				cnt_q   <= '0;
				phase_q <= ~phase_q;
			end else begin
				cnt_q   <= cnt_q + W'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// Registered ticks: serial clock every k, bit every 2k
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_q <= 1'b0;
			bit_q  <= 1'b0;
		end else begin
			sclk_q <= wrap;
			bit_q  <= wrap & phase_q;
		end
	end

	assign sclk_o = sclk_q;
	assign bit_o  = bit_q;
endmodule

// >>> rtl/ubd_top.sv
// Baud rate divider for three serial channels with an AXI4-Lite register slave.
// Assumes start-bit detection and framing live in the channel logic around it.
// Contract
// - Divisor register is 8 bits, read/write as one byte, resets to all ones.
// - Divisor accepts 4 to 255; 0 to 3 are prohibited settings.
// - Serial clock equals base clock divided by divisor k.
// - Baud rate equals base clock over twice k.
// - Internal source: baud is main clock over 2^(m+1) times k, m 0..10.
// - Channel 0 external pin as base clock: baud is pin rate over 2k.
// - After start bit, receive latch points are timed by the divisor counter.
// - Receive latch timing keeps a two base clock margin over 11 bits.
// - Base clock is the selected clock, supplied only while power is set.
// - Separate transmit and receive 8-bit counters share one divisor.
`timescale 1ns/1ps
module ubd_top
	import ubd_pkg::*;
#(
	parameter int AW = 14
) (
	// Clock and reset
	input  wire logic          mclk_i,
	input  wire logic          arst_n_i,
	// AXI4-Lite write address and data
	input  wire logic [AW-1:0] s_axi_awaddr_i,
	input  wire logic          s_axi_awvalid_i,
	output logic               s_axi_awready_o,
	input  wire logic [31:0]   s_axi_wdata_i,
	input  wire logic [3:0]    s_axi_wstrb_i,
	input  wire logic          s_axi_wvalid_i,
	output logic               s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]         s_axi_bresp_o,
	output logic               s_axi_bvalid_o,
	input  wire logic          s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [AW-1:0] s_axi_araddr_i,
	input  wire logic          s_axi_arvalid_i,
	output logic               s_axi_arready_o,
	output logic [31:0]        s_axi_rdata_o,
	output logic [1:0]         s_axi_rresp_o,
	output logic               s_axi_rvalid_o,
	input  wire logic          s_axi_rready_i,
	// Line side
	input  wire logic          ext_baud_clk_i,
	input  wire logic [NCH-1:0] rx_start_i,
	// Timing ticks
	output logic [NCH-1:0]     tx_sclk_o,
	output logic [NCH-1:0]     tx_bit_o,
	output logic [NCH-1:0]     rx_sclk_o,
	output logic [NCH-1:0]     rx_latch_o,
	output logic [NCH-1:0]     rx_active_o
);
	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic ubd_dec_s ubd_decode(input logic [AW-1:0] a);
		ubd_dec_s d;
		d = '0;
		for (int c = 0; c < NCH; c++) begin
			if (a[AW-1:2] == IDX_CTL[c][AW-3:0]) begin
				d = '{hit: 1'b1, ch: 2'(c), kind: KIND_CTL};
			end
			if (a[AW-1:2] == IDX_CKS[c][AW-3:0]) begin
				d = '{hit: 1'b1, ch: 2'(c), kind: KIND_CKS};
			end
			if (a[AW-1:2] == IDX_DIV[c][AW-3:0]) begin
				d = '{hit: 1'b1, ch: 2'(c), kind: KIND_DIV};
			end
		end
		return d;
	endfunction

	// True on the main clock cycles that form a fxx/2^m enable
	function automatic logic ubd_pre_hit(input logic [PRE_W-1:0] pre, input logic [CKS_W-1:0] m);
		logic [PRE_W-1:0] mask;
		mask = PRE_W'((32'h1 << m) - 32'h1);
		return (pre & mask) == mask;
	endfunction

	// ------------------------------------------------------------
	// Write channel: address and data taken in either order
	// ------------------------------------------------------------
	logic            aw_q;
	logic            w_q;
	logic [AW-1:0]   awaddr_q;
	logic [31:0]     wdata_q;
	logic [3:0]      wstrb_q;
	logic            bvalid_q;
	logic [1:0]      bresp_q;
	logic            wr_fire;
	ubd_dec_s        wr_dec;

	assign s_axi_awready_o = ~aw_q & ~bvalid_q;
	assign s_axi_wready_o  = ~w_q & ~bvalid_q;
	assign wr_fire         = aw_q & w_q & ~bvalid_q;
	assign wr_dec          = ubd_decode(awaddr_q);

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_q     <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_q     <= 1'b1;
			awaddr_q <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_q     <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_q     <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_q     <= 1'b1;
			wdata_q <= s_axi_wdata_i;
			wstrb_q <= s_axi_wstrb_i;
		end else if (wr_fire) begin
			w_q     <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o  = bresp_q;

	// ------------------------------------------------------------
	// Shared prescaler and external clock edge
	// ------------------------------------------------------------
	logic [PRE_W-1:0] pre_q;
	logic             ext_q;
	logic             ext_rise;

	// Free running so every channel sees the same fxx/2^m phase grid
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// Pin is taken as synchronous; its rising edge is one base clock
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= ext_baud_clk_i;
		end
	end

	assign ext_rise = ext_baud_clk_i & ~ext_q;

	// ------------------------------------------------------------
	// Per-channel registers and counters
	// ------------------------------------------------------------
	ubd_cfg_s         cfg_q  [NCH];
	logic [NCH-1:0]   rx_act_q;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic       wr_this;
		logic       sel_en;
		logic       base_en;
		logic       tx_run;
		logic       rx_run;
		logic       rx_restart;
		logic       rx_tick;
		logic [3:0] rx_cnt_q;

		assign wr_this = wr_fire & wr_dec.hit & wstrb_q[0] & (wr_dec.ch == 2'(c));

		// Divisor write of 0 to 3 is dropped; register keeps its value
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				cfg_q[c].power <= CTL_BIT_RST;
				cfg_q[c].txe   <= CTL_BIT_RST;
				cfg_q[c].rxe   <= CTL_BIT_RST;
				cfg_q[c].cks   <= CKS_RST;
				cfg_q[c].div   <= DIV_RST;
			end else if (wr_this) begin
				unique case (wr_dec.kind)
					KIND_CTL: begin
						cfg_q[c].power <= wdata_q[CTL_PWR_BIT];
						cfg_q[c].txe   <= wdata_q[CTL_TXE_BIT];
						cfg_q[c].rxe   <= wdata_q[CTL_RXE_BIT];
					end
					KIND_CKS: begin
						cfg_q[c].cks <= wdata_q[CKS_W-1:0];
					end
					KIND_DIV: begin
						if (wdata_q[DIV_W-1:0] >= DIV_MIN) begin
							cfg_q[c].div <= wdata_q[DIV_W-1:0];
						end
					end
					default: begin
					end
				endcase
			end
		end

		// External pin only on channel 0; other codes give no clock
		always_comb begin
			if (cfg_q[c].cks <= CKS_MAX_INT) begin
				sel_en = ubd_pre_hit(pre_q, cfg_q[c].cks);
			end else if (c == 0 && cfg_q[c].cks == CKS_EXT) begin
				sel_en = ext_rise;
			end else begin
				sel_en = 1'b0;
			end
		end

		assign base_en    = sel_en & cfg_q[c].power;
		assign tx_run     = cfg_q[c].power & cfg_q[c].txe;
		assign rx_restart = rx_start_i[c] & cfg_q[c].power & cfg_q[c].rxe;
		assign rx_run     = cfg_q[c].power & cfg_q[c].rxe & rx_act_q[c];

		// Two counters fed from one divisor setting
		ubd_div_counter #(
			.W             (DIV_W),
			.FIRST_AT_HALF (1'b0)
		) u_tx (
			.mclk_i    (mclk_i),
			.arst_n_i  (arst_n_i),
			.run_i     (tx_run),
			.restart_i (1'b0),
			.base_en_i (base_en),
			.div_i     (cfg_q[c].div),
			.sclk_o    (tx_sclk_o[c]),
			.bit_o     (tx_bit_o[c])
		);

		// First latch k base clocks after the start edge, mid start bit
		ubd_div_counter #(
			.W             (DIV_W),
			.FIRST_AT_HALF (1'b1)
		) u_rx (
			.mclk_i    (mclk_i),
			.arst_n_i  (arst_n_i),
			.run_i     (rx_run | rx_restart),
			.restart_i (rx_restart),
			.base_en_i (base_en),
			.div_i     (cfg_q[c].div),
			.sclk_o    (rx_sclk_o[c]),
			.bit_o     (rx_tick)
		);

		// Frame timed for 11 latch points, then idle until next start
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				rx_act_q[c] <= 1'b0;
				rx_cnt_q    <= '0;
			end else if (rx_restart) begin
				rx_act_q[c] <= 1'b1;
				rx_cnt_q    <= '0;
			end else if (!(cfg_q[c].power && cfg_q[c].rxe)) begin
				rx_act_q[c] <= 1'b0;
				rx_cnt_q    <= '0;
			end else if (rx_tick) begin
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q == FRAME_BITS - 4'h1) begin
					rx_act_q[c] <= 1'b0;
				end
			end
		end

		assign rx_latch_o[c]  = rx_tick;
		assign rx_active_o[c] = rx_act_q[c];
	end

	// ------------------------------------------------------------
	// Read channel: one read at a time, answer one edge later
	// ------------------------------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	ubd_dec_s    rd_dec;
	logic [7:0]  rd_byte;

	assign s_axi_arready_o = ~rvalid_q;
	assign rd_dec          = ubd_decode(s_axi_araddr_i);

	always_comb begin
		rd_byte = 8'h00;
		for (int c = 0; c < NCH; c++) begin
			if (rd_dec.hit && rd_dec.ch == 2'(c)) begin
				unique case (rd_dec.kind)
					KIND_CTL: begin
						rd_byte[CTL_PWR_BIT]   = cfg_q[c].power;
						rd_byte[CTL_TXE_BIT]   = cfg_q[c].txe;
						rd_byte[CTL_RXE_BIT]   = cfg_q[c].rxe;
						rd_byte[CTL_RXACT_BIT] = rx_act_q[c];
					end
					KIND_CKS: begin
						rd_byte[CKS_W-1:0] = cfg_q[c].cks;
					end
					KIND_DIV: begin
						rd_byte = cfg_q[c].div;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h000000, rd_byte};
			rresp_q  <= rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o  = rdata_q;
	assign s_axi_rresp_o  = rresp_q;
endmodule

// >>> test/ubd_props.sv
// Checker: bus answers and tick spacing of channel 0.
// Assumes binding to ubd_top and a divisor of 4 or more.
`timescale 1ns/1ps
module ubd_props
	import ubd_pkg::*;
(
	// Clock, reset, bus
	input wire logic		mclk_i,
	input wire logic		arst_n_i,
	input wire logic		s_axi_awvalid_i,
	input wire logic		s_axi_awready_o,
	input wire logic		s_axi_wvalid_i,
	input wire logic		s_axi_wready_o,
	input wire logic		s_axi_bvalid_o,
	input wire logic		s_axi_arvalid_i,
	input wire logic		s_axi_arready_o,
	input wire logic [31:0]	s_axi_rdata_o,
	input wire logic		s_axi_rvalid_o,
	// Ticks
	input wire logic [NCH-1:0]	tx_sclk_o,
	input wire logic [NCH-1:0]	tx_bit_o,
	input wire logic [NCH-1:0]	rx_latch_o,
	input wire logic [NCH-1:0]	rx_active_o
);
	// ---------
	// Sequences
	// ---------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	sequence tx_quiet;
		!tx_sclk_o[0] [*3];
	endsequence
	sequence rx_quiet;
		!rx_latch_o[0] [*4];
	endsequence
	// ---------
	// Properties
	// ---------
	wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|-> ##[1:2] s_axi_bvalid_o) else $error("no write answer");
	rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
		else $error("no read answer");
	byte_wide_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
		else $error("read data wider than a byte");
	rd_busy_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> !s_axi_arready_o)
		else $error("read taken while busy");
	rd_origin_a: assert property (s_axi_rvalid_o && !$past(s_axi_rvalid_o) |-> $past(s_axi_arvalid_i && s_axi_arready_o))
		else $error("read answer without request");
	sclk_gap_a: assert property (tx_sclk_o[0] |=> tx_quiet) else $error("serial clock too fast");
	bit_on_sclk_a: assert property (tx_bit_o[0] |-> tx_sclk_o[0]) else $error("bit off serial clock");
	latch_gap_a: assert property (rx_latch_o[0] |=> !rx_latch_o[0] [*3]) else $error("latches too close");
	latch_frame_a: assert property (rx_latch_o[0] |-> $past(rx_active_o[0]))
		else $error("latch outside a frame");
	first_latch_a: assert property ($rose(rx_active_o[0]) |-> rx_quiet) else $error("first latch too early");
endmodule

bind ubd_top ubd_props i_ubd_props (.mclk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
	.tx_sclk_o, .tx_bit_o, .rx_latch_o, .rx_active_o);

// >>> test/ubd_remote.sv
// Remote serial party: start pulses and external baud clock.
// Assumes the bench requests frames and clock runs.
`timescale 1ns/1ps
module ubd_remote
	import ubd_pkg::*;
(
	// Clock and reset
	input wire logic		mclk_i,
	input wire logic		arst_n_i,
	// Requests
	input wire logic		ext_run_i,
	input wire logic [7:0]	ext_half_i,
	input wire logic [NCH-1:0]	frame_go_i,
	// Line side
	output logic			ext_baud_clk_o,
	output logic [NCH-1:0]	rx_start_o
);
	logic [7:0]	cnt_q;
	// Clock stands low between runs; its rate is exact, so no rate error
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= 8'h00;
			ext_baud_clk_o <= 1'h0;
		end else if (!ext_run_i) begin
			cnt_q <= 8'h00;
			ext_baud_clk_o <= 1'h0;
		end else if (cnt_q == ext_half_i - 8'h01) begin
			cnt_q <= 8'h00;
			ext_baud_clk_o <= !ext_baud_clk_o;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// One start pulse per requested frame
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_start_o <= '0;
		end else begin
			rx_start_o <= frame_go_i;
		end
	end
endmodule

// >>> test/testbench.sv
// Bench: registers, tick spacing and receive framing.
// Assumes the remote model gives start pulses and external clock.
`timescale 1ns/1ps
module testbench
	import ubd_pkg::*;
;
	logic			mclk_i = 1'h0, arst_n_i = 1'h0;
	logic [13:0]	awaddr = '0, araddr = '0;
	logic [31:0]	wdata = '0, rdata, d;
	logic			awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic			awready, wready, bvalid, arready, rvalid, ext_clk, ext_run = 1'h0;
	logic [1:0]		bresp, rresp, r;
	logic [2:0]		go = '0, start, tsc, tbt, rsc, rlt, ract;
	int				error_cnt = 0, compares = 0, n, k, m, i;

	always #4 mclk_i = ~mclk_i;

	ubd_top i_ubd_top (.mclk_i, .arst_n_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_baud_clk_i(ext_clk),
		.rx_start_i(start), .tx_sclk_o(tsc), .tx_bit_o(tbt), .rx_sclk_o(rsc), .rx_latch_o(rlt),
		.rx_active_o(ract));
	ubd_remote i_ubd_remote (.mclk_i, .arst_n_i, .ext_run_i(ext_run), .ext_half_i(8'h03), .frame_go_i(go),
		.ext_baud_clk_o(ext_clk), .rx_start_o(start));

	// ---------
	// Helpers
	// ---------
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tmo(input int t, lim);
		if (t >= lim) begin
			error_cnt++;
			summarize();
		end
	endtask
	function automatic logic [13:0] adr(input int ch, kind);
		logic [31:0] x;
		x = (kind == 0) ? IDX_CTL[ch] : (kind == 1) ? IDX_CKS[ch] : IDX_DIV[ch];
		return {x[11:0], 2'h0};
	endfunction
	function automatic logic tick(input int sel, ch);
		case (sel)
			0: return tsc[ch];
			1: return tbt[ch];
			3: return rlt[ch];
			default: return start[ch];
		endcase
	endfunction
	// Expected tick spacing in main clocks: k base clocks per serial clock, 2k per bit
	function automatic int exp_gap(input int kk, mm, per_bit);
		return (per_bit != 0) ? (2 * kk) << mm : kk << mm;
	endfunction
	task automatic wr(input logic [13:0] a, input logic [31:0] dd, output logic [1:0] rr);
		int t;
		logic ta, tw, tb;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= dd;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (t = 0; t < 40; t++) begin
			@(negedge mclk_i);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rr = bresp;
			@(posedge mclk_i);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) break;
		end
		bready <= 1'h0;
		tmo(t, 40);
	endtask
	task automatic rd(input logic [13:0] a, output logic [31:0] dd, output logic [1:0] rr);
		int t;
		logic ta, tb;
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (t = 0; t < 40; t++) begin
			@(negedge mclk_i);
			ta = arvalid & arready;
			tb = rvalid;
			dd = rdata;
			rr = rresp;
			@(posedge mclk_i);
			if (ta) arvalid <= 1'h0;
			if (tb) break;
		end
		rready <= 1'h0;
		tmo(t, 40);
	endtask
	task automatic setup(input int ch, mm, kk, cc);
		wr(adr(ch, 0), 0, r); // power off before the divisor changes
		wr(adr(ch, 1), mm, r);
		wr(adr(ch, 2), kk, r);
		wr(adr(ch, 0), cc, r);
		chk(r, RESP_OKAY);
	endtask
	task automatic upto(input int sel, ch, output int c);
		for (c = 1; c < 9000; c++) begin
			@(negedge mclk_i);
			if (tick(sel, ch) === 1'h1) break;
		end
		tmo(c, 9000);
	endtask
	task automatic gap(input int sel, ch, output int c);
		upto(sel, ch, c);
		upto(sel, ch, c);
	endtask
	task automatic silent(input int sel, ch, len);
		int c = 0;
		repeat (len) begin
			@(negedge mclk_i);
			if (tick(sel, ch) === 1'h1) c++;
		end
		chk(c, 0);
	endtask
	task automatic pulse(input int ch);
		go[ch] <= 1'h1;
		@(posedge mclk_i);
		go[ch] <= 1'h0;
	endtask
	// Restart after the third latch shows that each start retimes the frame
	task automatic frame(input int ch, kk, input bit rs);
		int j, c;
		pulse(ch);
		upto(4, ch, c);
		for (j = 0; j < 11; j++) begin
			upto(3, ch, c);
			chk(c, (j == 0) ? kk + 1 : 2 * kk);
			chk({rsc[ch], ract[ch]}, 2'h3);
			if (rs && j == 2) begin
				rs = 1'b0;
				j = -1;
				pulse(ch);
				upto(4, ch, c);
			end
		end
		repeat (2) @(negedge mclk_i);
		chk(ract[ch], 1'h0);
		silent(3, ch, 60);
	endtask

	// ---------
	// Sequence
	// ---------
	initial begin
		void'($urandom(97));
		repeat (3) @(posedge mclk_i);
		arst_n_i <= 1'h1;
		for (i = 0; i < 9; i++) begin
			rd(adr(i % 3, i / 3), d, r);
			chk(d, (i / 3 == 2) ? 32'hFF : 32'h0);
		end
		$display("reset values done");
		for (i = 0; i < 3; i++) begin
			k = 4 + $urandom % 252;
			wr(adr(i, 2), ($urandom << 8) | k, r);
			wr(adr(i, 2), $urandom % 4, r);
			rd(adr(i, 2), d, r);
			chk(d, k);
		end
		wr(14'h0000, 32'h5, r);
		chk(r, RESP_SLVERR);
		rd(14'h0004, d, r);
		chk(d, 0);
		chk(r, RESP_SLVERR);
		$display("register access done");
		// Settings stay in the legal k and m ranges
		for (i = 0; i < 5; i++) begin
			k = (i == 1) ? 255 : (i == 0 || i == 2) ? 4 : 4 + $urandom % 13;
			m = (i == 2) ? 10 : (i < 2) ? 0 : $urandom % 3;
			setup(i % 3, m, k, 3);
			gap(0, i % 3, n);
			chk(n, exp_gap(k, m, 0));
			gap(1, i % 3, n);
			chk(n, exp_gap(k, m, 1));
		end
		ext_run <= 1'h1;
		setup(0, CKS_EXT, 5, 3);
		gap(1, 0, n);
		chk(n, 2 * 5 * 6);
		ext_run <= 1'h0;
		$display("transmit rates done");
		setup(1, 0, 4, 2);
		silent(0, 1, 200);
		// A prohibited select code must leave the divider without a base clock
		setup(1, 12, 4, 3);
		silent(0, 1, 200);
		setup(2, 0, 4, 3);
		pulse(2);
		silent(3, 2, 100);
		$display("power and enable gating done");
		for (i = 0; i < 3; i++) begin
			k = 4 + $urandom % 9;
			setup(i, 0, k, 7);
			frame(i, k, i == 1);
			gap(0, i, n);
			chk(n, exp_gap(k, 0, 0));
		end
		$display("receive framing done");
		summarize();
	end
endmodule
